// ---- design/antr_pkg.sv ----
/*
 * Constants, register map and carrier types for the negotiation and training
 * register bank. Assumes a 32-bit register bus with byte addresses and one
 * aligned word per register.
 */
package antr_pkg;
    localparam int ADDR_W = 12;
    localparam int NCFG = 12;

    localparam logic [ADDR_W-1:0] OFF_AN_CTL1 = 12'h0E0;
    localparam logic [ADDR_W-1:0] OFF_SPEED = 12'h13C;
    localparam logic [ADDR_W-1:0] OFF_TX_STAT = 12'h400;
    localparam logic [ADDR_W-1:0] OFF_RX_STAT = 12'h404;

    // config register indices
    localparam int CI_AN1 = 0;
    localparam int CI_AN2 = 1;
    localparam int CI_ABIL = 2;
    localparam int CI_LTCTL = 3;
    localparam int CI_TRAINED = 4;
    localparam int CI_PRESET = 5;
    localparam int CI_INIT = 6;
    localparam int CI_SEED01 = 7;
    localparam int CI_SEED23 = 8;
    localparam int CI_COEF01 = 9;
    localparam int CI_COEF23 = 10;
    localparam int CI_USER = 11;

    localparam logic [ADDR_W-1:0] CFG_OFF [NCFG] = '{
        12'h0E0, 12'h0E4, 12'h0F8, 12'h100, 12'h104, 12'h108,
        12'h10C, 12'h110, 12'h114, 12'h130, 12'h134, 12'h138};
    localparam logic [31:0] CFG_MASK [NCFG] = '{
        32'h0000_1FFF, 32'h003F_0003, 32'h000F_FFFF, 32'h0000_0003,
        32'h0000_000F, 32'h0000_000F, 32'h0000_000F, 32'h07FF_07FF,
        32'h07FF_07FF, 32'h0FFF_0FFF, 32'h0FFF_0FFF, 32'hFFFF_FFFF};
    localparam logic [31:0] CFG_RST [NCFG] = '{
        32'h0000_0002, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000,
        32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000,
        32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000};

    localparam int SWITCH_BIT = 0;
    localparam int AN2_PAUSE_LSB = 0;
    localparam int AN2_FEC_LSB = 16;
    localparam int SEED_HI_LSB = 16;
    localparam int COEF_HI_LSB = 16;

    localparam int TX_STAT_W = 1;
    localparam int RX_STAT_W = 12;
    localparam logic [TX_STAT_W-1:0] TX_LL_MASK = 1'h0;
    localparam logic [TX_STAT_W-1:0] TX_STAT_RST = 1'h0;
    localparam logic [RX_STAT_W-1:0] RX_LL_MASK = 12'h003;
    localparam logic [RX_STAT_W-1:0] RX_STAT_RST = 12'h003;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // layout of the first negotiation control register, bit 0 at the bottom
    typedef struct packed {
        logic localFault;
        logic restartNeg;
        logic pseudoSel;
        logic [7:0] nonceSeed;
        logic bypass;
        logic enable;
    } antr_an_ctl_t;

    // one lane's coefficient field, bit 0 at the bottom
    typedef struct packed {
        logic [1:0] statM1;
        logic [1:0] stat0;
        logic [1:0] statP1;
        logic [1:0] kM1;
        logic [1:0] k0;
        logic [1:0] kP1;
    } antr_lt_coef_t;

    typedef struct packed {
        logic hit;
        logic [3:0] idx;
    } antr_hit_t;

    function automatic antr_hit_t antr_cfg_decode(input logic [ADDR_W-1:0] addr);
        antr_hit_t res;
        res = '0;
        for (int i = 0; i < NCFG; i++) begin
            if ({addr[ADDR_W-1:2], 2'h0} == CFG_OFF[i]) begin
                res.hit = 1'b1;
                res.idx = 4'(i);
            end
        end
        return res;
    endfunction

    function automatic logic [31:0] antr_merge(input logic [31:0] old,
                                               input logic [31:0] data,
                                               input logic [3:0] strb);
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                res[b*8 +: 8] = data[b*8 +: 8];
            end
        end
        return res;
    endfunction
endpackage

// ---- design/antr_sync.sv ----
/*
 * Three-stage synchroniser for a status vector. Assumes the inputs come from
 * another clock domain; a bit's change is taken once stages two and three agree.
 */
`timescale 1ns/1ps
module antr_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST = '0
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    logic [W-1:0] s1Q;
    logic [W-1:0] s2Q;
    logic [W-1:0] s3Q;
    logic [W-1:0] outQ;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            s1Q <= RST;
            s2Q <= RST;
            s3Q <= RST;
        end else begin
            s1Q <= din;
            s2Q <= s1Q;
            s3Q <= s2Q;
        end
    end

    // filters a one-cycle metastable glitch out of stage three
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            outQ <= RST;
        end else begin
            outQ <= (s2Q & s3Q) | (~(s2Q ^ s3Q) & s3Q) | ((s2Q ^ s3Q) & outQ);
        end
    end

    assign dout = outQ;
endmodule

// ---- design/antr_latch.sv ----
/*
 * Sticky status latches, high or low per bit. Assumes the condition inputs are
 * already in this clock domain and rel pulses for one cycle on a register read.
 */
`timescale 1ns/1ps
module antr_latch #(
    parameter int W = 1,
    parameter logic [W-1:0] LOW_MASK = '0,
    parameter logic [W-1:0] RST = '0
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [W-1:0] cond,
    input wire logic rel,
    output logic [W-1:0] q
);
    logic [W-1:0] latQ;

    for (genvar i = 0; i < W; i++) begin : gBit
        always_ff @(posedge clk or negedge rst_b) begin
            if (!rst_b) begin
                latQ[i] <= RST[i];
            end else if (LOW_MASK[i]) begin
                // low latch; a new drop in the read cycle still wins
                latQ[i] <= cond[i] & (latQ[i] | rel);
            end else begin
                latQ[i] <= cond[i] | (latQ[i] & ~rel);
            end
        end
    end

    assign q = latQ;

    latch_high_hold_a: assert property (@(posedge clk) disable iff (!rst_b)
        !rel |=> ((($past(latQ) | $past(cond)) & ~LOW_MASK & ~latQ) == '0))
        else $error("latched-high bit dropped without a read");
    latch_low_hold_a: assert property (@(posedge clk) disable iff (!rst_b)
        !rel |=> ((latQ & LOW_MASK & ~($past(latQ) & $past(cond))) == '0))
        else $error("latched-low bit rose without a read");
    read_release_a: assert property (@(posedge clk) disable iff (!rst_b)
        rel |=> (latQ == $past(cond)))
        else $error("latch did not follow the live condition after read");
endmodule

// ---- design/antr_regs.sv ----
/*
 * Negotiation and training register bank with its AXI4-Lite slave, the
 * self-clearing speed-switch request and the first transmit and receive
 * status registers. Assumes one register bus clock; status inputs arrive
 * from another domain and are synchronised here.
 */
`timescale 1ns/1ps
module antr_regs
    import antr_pkg::*;
#(
    parameter bit RUNTIME_SWITCH = 1'b1
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [TX_STAT_W-1:0] txStatusIn,
    input wire logic [RX_STAT_W-1:0] rxStatusIn,
    output antr_an_ctl_t anCtl,
    output logic [1:0] anPauseCtl,
    output logic [5:0] anFecCtl,
    output logic [19:0] anAbility,
    output logic ltTrainEnable,
    output logic ltRestartTraining,
    output logic [3:0] ltRxTrained,
    output logic [3:0] ltPresetToTx,
    output logic [3:0] ltInitToTx,
    output logic [3:0][10:0] ltSeed,
    output antr_lt_coef_t [3:0] ltCoef,
    output logic [31:0] userReg,
    output logic speedSwitchReq
);
    logic [31:0] cfgQ [NCFG];
    logic awreadyQ;
    logic bvalidQ;
    logic [1:0] brespQ;
    logic arreadyQ;
    logic rvalidQ;
    logic [1:0] rrespQ;
    logic [31:0] rdataQ;
    logic speedQ;
    logic wrFire;
    logic rdFire;
    antr_hit_t wHit;
    antr_hit_t rHit;
    logic [31:0] rdMux;
    logic rdOk;
    logic txRel;
    logic rxRel;
    logic [TX_STAT_W-1:0] txSync;
    logic [RX_STAT_W-1:0] rxSync;
    logic [TX_STAT_W-1:0] txLat;
    logic [RX_STAT_W-1:0] rxLat;
    logic an1WrittenQ;

    assign wHit = antr_cfg_decode(s_axi_awaddr);
    assign rHit = antr_cfg_decode(s_axi_araddr);
    assign wrFire = s_axi_awvalid & s_axi_wvalid & awreadyQ;
    assign rdFire = s_axi_arvalid & arreadyQ;

    // write channel: address and data taken together, one write in flight
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            awreadyQ <= 1'b0;
        end else begin
            awreadyQ <= s_axi_awvalid & s_axi_wvalid & ~awreadyQ & ~bvalidQ;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            bvalidQ <= 1'b0;
            brespQ <= RESP_OKAY;
        end else if (wrFire) begin
            bvalidQ <= 1'b1;
            if (wHit.hit || {s_axi_awaddr[ADDR_W-1:2], 2'h0} == OFF_SPEED
                || {s_axi_awaddr[ADDR_W-1:2], 2'h0} == OFF_TX_STAT
                || {s_axi_awaddr[ADDR_W-1:2], 2'h0} == OFF_RX_STAT) begin
                brespQ <= RESP_OKAY;
            end else begin
                brespQ <= RESP_SLVERR;
            end
        end else if (s_axi_bready) begin
            bvalidQ <= 1'b0;
        end
    end

    // configuration words, byte-strobed, unused bits forced to zero
    for (genvar g = 0; g < NCFG; g++) begin : gCfg
        always_ff @(posedge clk or negedge rst_b) begin
            if (!rst_b) begin
                cfgQ[g] <= CFG_RST[g];
            end else if (wrFire && wHit.hit && wHit.idx == 4'(g)) begin
                cfgQ[g] <= antr_merge(cfgQ[g], s_axi_wdata, s_axi_wstrb)
                           & CFG_MASK[g];
            end
        end
    end

    // one-cycle request; nothing is stored, so a read returns zero
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            speedQ <= 1'b0;
        end else begin
            speedQ <= RUNTIME_SWITCH
                      & wrFire
                      & ({s_axi_awaddr[ADDR_W-1:2], 2'h0} == OFF_SPEED)
                      & s_axi_wstrb[0]
                      & s_axi_wdata[SWITCH_BIT];
        end
    end

    assign speedSwitchReq = speedQ;

    // status path
    antr_sync #(.W(TX_STAT_W), .RST(TX_STAT_RST)) uTxSync (
        .clk(clk),
        .rst_b(rst_b),
        .din(txStatusIn),
        .dout(txSync)
    );

    antr_sync #(.W(RX_STAT_W), .RST(RX_STAT_RST)) uRxSync (
        .clk(clk),
        .rst_b(rst_b),
        .din(rxStatusIn),
        .dout(rxSync)
    );

    assign txRel = rdFire & ({s_axi_araddr[ADDR_W-1:2], 2'h0} == OFF_TX_STAT);
    assign rxRel = rdFire & ({s_axi_araddr[ADDR_W-1:2], 2'h0} == OFF_RX_STAT);

    antr_latch #(.W(TX_STAT_W), .LOW_MASK(TX_LL_MASK), .RST(TX_STAT_RST)) uTxLat (
        .clk(clk),
        .rst_b(rst_b),
        .cond(txSync),
        .rel(txRel),
        .q(txLat)
    );

    antr_latch #(.W(RX_STAT_W), .LOW_MASK(RX_LL_MASK), .RST(RX_STAT_RST)) uRxLat (
        .clk(clk),
        .rst_b(rst_b),
        .cond(rxSync),
        .rel(rxRel),
        .q(rxLat)
    );

    // read mux
    always_comb begin
        rdMux = '0;
        rdOk = 1'b1;
        if (rHit.hit) begin
            rdMux = cfgQ[rHit.idx] & CFG_MASK[rHit.idx];
        end else begin
            unique case ({s_axi_araddr[ADDR_W-1:2], 2'h0})
                OFF_SPEED: rdMux = '0;
                OFF_TX_STAT: rdMux = 32'(txLat);
                OFF_RX_STAT: rdMux = 32'(rxLat);
                default: rdOk = 1'b0;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            arreadyQ <= 1'b0;
        end else begin
            arreadyQ <= s_axi_arvalid & ~arreadyQ & ~rvalidQ;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rvalidQ <= 1'b0;
            rdataQ <= '0;
            rrespQ <= RESP_OKAY;
        end else if (rdFire) begin
            rvalidQ <= 1'b1;
            rdataQ <= rdMux;
            rrespQ <= rdOk ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rready) begin
            rvalidQ <= 1'b0;
        end
    end

    assign s_axi_awready = awreadyQ;
    assign s_axi_wready = awreadyQ;
    assign s_axi_bvalid = bvalidQ;
    assign s_axi_bresp = brespQ;
    assign s_axi_arready = arreadyQ;
    assign s_axi_rvalid = rvalidQ;
    assign s_axi_rdata = rdataQ;
    assign s_axi_rresp = rrespQ;

    // control outputs, straight from the configuration flops
    assign anCtl = antr_an_ctl_t'(cfgQ[CI_AN1][$bits(antr_an_ctl_t)-1:0]);
    assign anPauseCtl = cfgQ[CI_AN2][AN2_PAUSE_LSB +: 2];
    assign anFecCtl = cfgQ[CI_AN2][AN2_FEC_LSB +: 6];
    assign anAbility = cfgQ[CI_ABIL][19:0];
    assign ltTrainEnable = cfgQ[CI_LTCTL][0];
    assign ltRestartTraining = cfgQ[CI_LTCTL][1];
    assign ltRxTrained = cfgQ[CI_TRAINED][3:0];
    assign ltPresetToTx = cfgQ[CI_PRESET][3:0];
    assign ltInitToTx = cfgQ[CI_INIT][3:0];
    assign ltSeed[0] = cfgQ[CI_SEED01][10:0];
    assign ltSeed[1] = cfgQ[CI_SEED01][SEED_HI_LSB +: 11];
    assign ltSeed[2] = cfgQ[CI_SEED23][10:0];
    assign ltSeed[3] = cfgQ[CI_SEED23][SEED_HI_LSB +: 11];
    assign ltCoef[0] = antr_lt_coef_t'(cfgQ[CI_COEF01][11:0]);
    assign ltCoef[1] = antr_lt_coef_t'(cfgQ[CI_COEF01][COEF_HI_LSB +: 12]);
    assign ltCoef[2] = antr_lt_coef_t'(cfgQ[CI_COEF23][11:0]);
    assign ltCoef[3] = antr_lt_coef_t'(cfgQ[CI_COEF23][COEF_HI_LSB +: 12]);
    assign userReg = cfgQ[CI_USER];

    // helper for checks: first control word touched since reset
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            an1WrittenQ <= 1'b0;
        end else if (wrFire && wHit.hit && wHit.idx == 4'(CI_AN1)) begin
            an1WrittenQ <= 1'b1;
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    bypass_default_a: assert property (
        !an1WrittenQ |-> anCtl.bypass && !anCtl.enable)
        else $error("bypass not set before first control write");
    switch_start_a: assert property (
        wrFire && {s_axi_awaddr[ADDR_W-1:2], 2'h0} == OFF_SPEED
        && s_axi_wstrb[0] && s_axi_wdata[SWITCH_BIT] && RUNTIME_SWITCH
        |=> speedSwitchReq)
        else $error("speed switch write did not raise the request");
    switch_selfclear_a: assert property (
        speedSwitchReq |=> (!speedSwitchReq)[*2])
        else $error("speed switch request did not clear itself");
    switch_cause_a: assert property (
        speedSwitchReq |-> $past(wrFire) && $past(s_axi_wdata[SWITCH_BIT]))
        else $error("speed switch request without a write of one");
    switch_build_a: assert property (
        !RUNTIME_SWITCH |-> !speedSwitchReq)
        else $error("speed switch request outside runtime switch build");
    user_hold_a: assert property (
        wrFire && wHit.hit && wHit.idx == 4'(CI_USER) && s_axi_wstrb == 4'hF
        |=> userReg == $past(s_axi_wdata) ##1 (wrFire || userReg == $past(userReg)))
        else $error("user word not held after write");
    read_reserved_a: assert property (
        rdFire && rHit.hit |=> (s_axi_rdata & ~CFG_MASK[$past(rHit.idx)]) == '0)
        else $error("unassigned bits read as nonzero");
    write_resp_a: assert property (
        wrFire |=> s_axi_bvalid && !s_axi_awready)
        else $error("write not answered one cycle after acceptance");

    // handshake as seen on the bus; ready is a one-cycle pulse
    aw_pulse_a: assert property (
        s_axi_awready |=> !s_axi_awready)
        else $error("write ready stood for more than one cycle");
    busy_refuse_a: assert property (
        s_axi_bvalid |-> !s_axi_awready)
        else $error("write taken while a response was pending");
    bresp_hold_a: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped before it was taken");
    bresp_unmapped_a: assert property (
        wrFire && !wHit.hit && {s_axi_awaddr[ADDR_W-1:2], 2'h0} != OFF_SPEED
        && {s_axi_awaddr[ADDR_W-1:2], 2'h0} != OFF_TX_STAT
        && {s_axi_awaddr[ADDR_W-1:2], 2'h0} != OFF_RX_STAT
        |=> s_axi_bresp == RESP_SLVERR)
        else $error("unmapped write not refused");
    read_resp_a: assert property (
        rdFire |=> s_axi_rvalid && !s_axi_arready)
        else $error("read not answered one cycle after acceptance");
    rdata_hold_a: assert property (
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data changed before it was taken");
    rresp_unmapped_a: assert property (
        rdFire && !rHit.hit && {s_axi_araddr[ADDR_W-1:2], 2'h0} != OFF_SPEED
        && {s_axi_araddr[ADDR_W-1:2], 2'h0} != OFF_TX_STAT
        && {s_axi_araddr[ADDR_W-1:2], 2'h0} != OFF_RX_STAT
        |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == '0)
        else $error("unmapped read not refused with zero data");

    // contents through the bus; status reads must show the latch, not the live pin
    switch_read_a: assert property (
        rdFire && {s_axi_araddr[ADDR_W-1:2], 2'h0} == OFF_SPEED |=> s_axi_rdata == '0)
        else $error("speed switch register read back nonzero");
    tx_read_a: assert property (
        txRel |=> s_axi_rdata == 32'($past(txLat)))
        else $error("transmit status read did not return the latch");
    rx_read_a: assert property (
        rxRel |=> s_axi_rdata == 32'($past(rxLat)))
        else $error("receive status read did not return the latch");
    hole_write_a: assert property (
        wrFire && !wHit.hit |=> $stable(anCtl) && $stable(userReg))
        else $error("write outside the configuration words changed a control");
endmodule

// ---- sim/tb_antr_regs.sv ----
/*
 * Self-checking bench for the negotiation and training register bank.
 * Assumes the antr_pkg map and masks, one 100 MHz clock and that the bench
 * alone drives every register bus and status input of both instances.
 */
`timescale 1ns/1ps
module tb_antr_regs;
    import antr_pkg::*;

    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic [ADDR_W-1:0] awAddr = '0;
    logic awValid = 1'b0;
    logic awReady;
    logic awReadyFixed;
    logic [31:0] wData = '0;
    logic [3:0] wStrb = '0;
    logic wValid = 1'b0;
    logic wReady;
    logic [1:0] bResp;
    logic bValid;
    logic bReady = 1'b0;
    logic [ADDR_W-1:0] arAddr = '0;
    logic arValid = 1'b0;
    logic arReady;
    logic [31:0] rData;
    logic [1:0] rResp;
    logic rValid;
    logic rReady = 1'b0;
    logic [TX_STAT_W-1:0] txStatusIn = '0;
    logic [RX_STAT_W-1:0] rxStatusIn = 12'h003;
    antr_an_ctl_t anCtl;
    logic [1:0] anPauseCtl;
    logic [5:0] anFecCtl;
    logic [19:0] anAbility;
    logic ltTrainEnable;
    logic ltRestartTraining;
    logic [3:0] ltRxTrained;
    logic [3:0] ltPresetToTx;
    logic [3:0] ltInitToTx;
    logic [3:0][10:0] ltSeed;
    antr_lt_coef_t [3:0] ltCoef;
    logic [31:0] userReg;
    logic speedSwitchReq;
    logic speedSwitchReqFixed;
    int n_fail = 0;
    int num_checks = 0;
    int cycles = 0;
    int nPulse = 0;
    int nPulseFixed = 0;
    logic [31:0] rd;
    logic [1:0] rs;

    always #5 clk = ~clk;

    antr_regs #(.RUNTIME_SWITCH(1'b1)) u_antr_regs (
        .clk(clk), .rst_b(rst_b), .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid),
        .s_axi_awready(awReady), .s_axi_wdata(wData), .s_axi_wstrb(wStrb),
        .s_axi_wvalid(wValid), .s_axi_wready(wReady), .s_axi_bresp(bResp),
        .s_axi_bvalid(bValid), .s_axi_bready(bReady), .s_axi_araddr(arAddr),
        .s_axi_arvalid(arValid), .s_axi_arready(arReady), .s_axi_rdata(rData),
        .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady),
        .txStatusIn(txStatusIn), .rxStatusIn(rxStatusIn), .anCtl(anCtl),
        .anPauseCtl(anPauseCtl), .anFecCtl(anFecCtl), .anAbility(anAbility),
        .ltTrainEnable(ltTrainEnable), .ltRestartTraining(ltRestartTraining),
        .ltRxTrained(ltRxTrained), .ltPresetToTx(ltPresetToTx), .ltInitToTx(ltInitToTx),
        .ltSeed(ltSeed), .ltCoef(ltCoef), .userReg(userReg),
        .speedSwitchReq(speedSwitchReq));

    // fixed-rate build shares the bus; only its write ready and switch output are watched
    antr_regs #(.RUNTIME_SWITCH(1'b0)) u_antr_regs_fixed (
        .clk(clk), .rst_b(rst_b), .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid),
        .s_axi_awready(awReadyFixed), .s_axi_wdata(wData), .s_axi_wstrb(wStrb),
        .s_axi_wvalid(wValid), .s_axi_wready(), .s_axi_bresp(), .s_axi_bvalid(),
        .s_axi_bready(bReady), .s_axi_araddr(arAddr), .s_axi_arvalid(arValid),
        .s_axi_arready(), .s_axi_rdata(), .s_axi_rresp(), .s_axi_rvalid(),
        .s_axi_rready(rReady), .txStatusIn(txStatusIn), .rxStatusIn(rxStatusIn),
        .anCtl(), .anPauseCtl(), .anFecCtl(), .anAbility(), .ltTrainEnable(),
        .ltRestartTraining(), .ltRxTrained(), .ltPresetToTx(), .ltInitToTx(),
        .ltSeed(), .ltCoef(), .userReg(), .speedSwitchReq(speedSwitchReqFixed));

    always @(posedge clk) begin
        if (speedSwitchReq === 1'b1) nPulse++;
        if (speedSwitchReqFixed === 1'b1) nPulseFixed++;
        cycles++;
        // generous ceiling; the whole run needs well under a thousand cycles
        if (cycles >= 5000) begin
            n_fail++;
            tally_and_finish();
        end
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
        int k;
        awAddr = a;
        wData = d;
        wStrb = s;
        awValid = 1'b1;
        wValid = 1'b1;
        k = 0;
        do begin @(posedge clk); k++; end while (awReady !== 1'b1 && k < 20);
        check("wready", 32'(wReady), 32'h1);
        check("fixed ready", 32'(awReadyFixed), 32'h1);
        #1 awValid = 1'b0;
        wValid = 1'b0;
        do begin @(posedge clk); k++; end while (bValid !== 1'b1 && k < 40);
        if (k >= 40) n_fail++;
        // late ready, so the response must stand a cycle
        #1 bReady = 1'b1;
        @(posedge clk);
        rs = bResp;
        #1 bReady = 1'b0;
        @(posedge clk);
        #1;
    endtask

    task automatic rdw(input logic [11:0] a);
        int k;
        arAddr = a;
        arValid = 1'b1;
        k = 0;
        do begin @(posedge clk); k++; end while (arReady !== 1'b1 && k < 20);
        #1 arValid = 1'b0;
        do begin @(posedge clk); k++; end while (rValid !== 1'b1 && k < 40);
        if (k >= 40) n_fail++;
        #1 rReady = 1'b1;
        @(posedge clk);
        rd = rData;
        rs = rResp;
        #1 rReady = 1'b0;
        @(posedge clk);
        #1;
    endtask

    task automatic wait_cycles(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic test_config();
        check("bypass out", 32'(anCtl), 32'h2);
        for (int i = 0; i < NCFG; i++) begin
            rdw(CFG_OFF[i]);
            check("cfg reset", rd, CFG_RST[i]);
            wr(CFG_OFF[i], 32'hFFFF_FFFF, 4'hF);
            check("cfg bresp", 32'(rs), 32'(RESP_OKAY));
            rdw(CFG_OFF[i]);
            check("cfg masked", rd, CFG_MASK[i]);
        end
        check("anCtl all", 32'(anCtl), 32'h1FFF);
        check("fec out", 32'(anFecCtl), 32'h3F);
        check("ability out", 32'(anAbility), 32'hF_FFFF);
        check("seed out", 32'(ltSeed[2]), 32'h7FF);
        check("train out", 32'({ltTrainEnable, ltRestartTraining, ltInitToTx}), 32'h3F);
        check("pause out", 32'(anPauseCtl), 32'h3);
        check("lane ctl out", 32'({ltRxTrained, ltPresetToTx}), 32'hFF);
        check("seed lanes01", 32'({ltSeed[1], ltSeed[0]}), 32'h3F_FFFF);
        check("seed lane3", 32'(ltSeed[3]), 32'h7FF);
        check("coef lanes23", 32'({ltCoef[3], ltCoef[2]}), 32'hFF_FFFF);
        wr(12'h138, 32'h1234_5678, 4'h5);
        check("user strobe", userReg, 32'hFF34_FF78);
        wr(12'h130, 32'h0ABC_0123, 4'hF);
        check("coef lane0", 32'(ltCoef[0]), 32'h123);
        check("coef lane1", 32'(ltCoef[1]), 32'hABC);
        wr(OFF_AN_CTL1, 32'h0000_0001, 4'hF);
        check("neg enabled", 32'(anCtl), 32'h1);
    endtask

    task automatic test_speed();
        int p0;
        int f0;
        p0 = nPulse;
        f0 = nPulseFixed;
        wr(OFF_SPEED, 32'h1, 4'hF);
        wr(OFF_SPEED, 32'h1, 4'hF);
        wait_cycles(3);
        check("switch pulses", 32'(nPulse - p0), 32'h2);
        check("fixed pulses", 32'(nPulseFixed - f0), 32'h0);
        rdw(OFF_SPEED);
        check("switch cleared", rd, 32'h0);
        check("switch out", 32'(speedSwitchReq), 32'h0);
        wr(OFF_SPEED, 32'h0, 4'hF);
        wait_cycles(3);
        check("no pulse on 0", 32'(nPulse - p0), 32'h2);
    endtask

    task automatic test_status();
        rdw(OFF_RX_STAT);
        check("rx reset", rd, 32'h003);
        rxStatusIn[2] = 1'b1;
        txStatusIn = 1'b1;
        wait_cycles(10);
        rxStatusIn[2] = 1'b0;
        txStatusIn = 1'b0;
        rxStatusIn[1] = 1'b0;
        wait_cycles(10);
        rxStatusIn[1] = 1'b1;
        wait_cycles(10);
        rdw(OFF_RX_STAT);
        check("rx latched", rd, 32'h005);
        rdw(OFF_TX_STAT);
        check("tx latched", rd, 32'h1);
        rdw(OFF_RX_STAT);
        check("rx released", rd, 32'h003);
        rdw(OFF_TX_STAT);
        check("tx released", rd, 32'h0);
        // status is read-only: a write answers okay and leaves the latches alone
        wr(OFF_RX_STAT, 32'h0, 4'hF);
        check("ro bresp", 32'(rs), 32'(RESP_OKAY));
        rdw(OFF_RX_STAT);
        check("ro kept", rd, 32'h003);
    endtask

    task automatic test_unmapped();
        wr(12'h0E8, 32'hFFFF_FFFF, 4'hF);
        check("hole bresp", 32'(rs), 32'(RESP_SLVERR));
        rdw(12'h0E8);
        check("hole rresp", 32'(rs), 32'(RESP_SLVERR));
        check("hole rdata", rd, 32'h0);
        check("hole no effect", 32'(anCtl), 32'h1);
    endtask

    task automatic test_reset();
        rst_b = 1'b0;
        wait_cycles(2);
        check("rst bypass", 32'(anCtl), 32'h2);
        check("rst bus idle", 32'({bValid, rValid, awReady, arReady, speedSwitchReq}), 32'h0);
        rst_b = 1'b1;
        wait_cycles(1);
        check("rst user", userReg, 32'h0);
        rdw(OFF_AN_CTL1);
        check("rst bypass read", rd, 32'h2);
        rdw(OFF_RX_STAT);
        check("rst rx", rd, 32'h003);
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    initial begin
        wait_cycles(2);
        rst_b = 1'b1;
        wait_cycles(1);
        test_config();
        test_speed();
        test_status();
        test_unmapped();
        test_reset();
        tally_and_finish();
    end
endmodule
